// ==== dv/adpr_asserts.sv ====
// watches the link between the controller end and the device end
module adpr_asserts
  import adpr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic power_down_reset_n,
  input wire logic input_format_sel_lo,
  input wire logic input_format_sel_hi,
  input wire logic word_len_18,
  input wire logic deemphasis_sel,
  input wire logic word_gap,
  input wire logic word_start,
  input wire logic powered_down,
  input wire logic amp_short,
  input wire logic engine_run,
  input wire adpr_fmt_type fmt_mode,
  input wire logic deemph_on,
  input wire logic dev_word_len_18,
  input wire logic [CHAN_REG_W-1:0] chan_ctl_left,
  input wire logic [CHAN_REG_W-1:0] chan_ctl_right,
  input wire logic [17:0] engine_acc
);
  logic [3:0] pins;
  logic [3:0] pins_r;
  logic [3:0] calm_r;
  assign pins = {input_format_sel_hi, input_format_sel_lo, word_len_18, deemphasis_sel};
  // edges the config pins held still with the pin high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pins_r <= 4'h0;
      calm_r <= 4'h0;
    end else begin
      pins_r <= pins;
      if (!power_down_reset_n || pins_r != pins) begin
        calm_r <= 4'h0;
      end else if (calm_r != 4'hF) begin
        calm_r <= calm_r + 4'h1;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_PD_STATE: assert property (!power_down_reset_n |-> powered_down && amp_short && !engine_run)
    else $error("power-down state missing");
  AST_RESET_CLEAR: assert property (!power_down_reset_n |-> chan_ctl_left == CHAN_REG_RESET
    && chan_ctl_right == CHAN_REG_RESET && engine_acc == 18'h00000) else $error("reset values wrong");
  AST_RELEASE_SYNC: assert property ($rose(power_down_reset_n)
    |-> powered_down ##1 powered_down ##[1:3] !powered_down) else $error("release not synchronised");
  AST_RUN_START: assert property ($fell(powered_down) |-> ##[1:3] (engine_run && !amp_short))
    else $error("run state late");
  AST_RUN_UNSHORT: assert property (engine_run |-> !amp_short)
    else $error("amplifiers shorted in run");
  AST_MIN_LOW: assert property ($fell(power_down_reset_n) |-> !power_down_reset_n [*4])
    else $error("reset pin low too short");
  AST_PIN_GAP: assert property (!word_gap && power_down_reset_n |=> $stable(pins))
    else $error("config pins moved inside a word");
  AST_CFG_APPLY: assert property (word_start && calm_r >= 4'h8 |-> ##2 (!power_down_reset_n
    || calm_r < 4'hA || (fmt_mode == adpr_fmt_type'(pins[3:2]) && dev_word_len_18 == pins[1]
    && deemph_on == pins[0]))) else $error("config not applied");
  AST_CFG_HOLD: assert property (!word_start && !$past(word_start) && engine_run
    |=> !power_down_reset_n || ($stable(fmt_mode) && $stable(deemph_on) && $stable(dev_word_len_18)))
    else $error("config moved early");
endmodule

// ==== dv/adpr_tb_top.sv ====
module adpr_tb_top
  import adpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, pd_req, wl_req, de_req, word_gap, word_start, ctl_wr, ctl_chan, engine_en, ready;
  logic powered_down, amp_short, engine_run, word_len_18, deemph_on, b_pd, b_sh, b_run, b_wl, b_de;
  logic [1:0] fmt_req;
  logic [3:0] cfg;
  logic [6:0] ctl_data, chan_ctl_left, chan_ctl_right, b_l, b_r, lv, rv;
  logic [17:0] engine_in, engine_acc, b_acc;
  logic [31:0] rnd, mrnd;
  adpr_fmt_type fmt_mode, b_fmt;
  integer seed, err_total, num_checks, i, k;
  adpr_if link_a();
  adpr_if link_b();
  adpr_ctrl i_adpr_ctrl (.mclk, .arst_n, .link(link_a), .pd_req, .fmt_req, .word_len_18_req(wl_req),
    .deemph_req(de_req), .word_gap, .ready);
  adpr_dev i_adpr_dev (.mclk, .link(link_a), .word_start, .ctl_wr, .ctl_chan, .ctl_data, .engine_in,
    .engine_en, .powered_down, .amp_short, .engine_run, .fmt_mode, .word_len_18, .deemph_on,
    .chan_ctl_left, .chan_ctl_right, .engine_acc);
  adpr_dev i_adpr_dev_b (.mclk, .link(link_b), .word_start, .ctl_wr, .ctl_chan, .ctl_data, .engine_in,
    .engine_en, .powered_down(b_pd), .amp_short(b_sh), .engine_run(b_run), .fmt_mode(b_fmt),
    .word_len_18(b_wl), .deemph_on(b_de), .chan_ctl_left(b_l), .chan_ctl_right(b_r), .engine_acc(b_acc));
  adpr_asserts i_adpr_asserts (.mclk, .arst_n, .power_down_reset_n(link_a.power_down_reset_n),
    .input_format_sel_lo(link_a.input_format_sel_lo), .input_format_sel_hi(link_a.input_format_sel_hi),
    .word_len_18(link_a.word_len_18), .deemphasis_sel(link_a.deemphasis_sel), .word_gap, .word_start,
    .powered_down, .amp_short, .engine_run, .fmt_mode, .deemph_on, .chan_ctl_left, .chan_ctl_right,
    .engine_acc, .dev_word_len_18(word_len_18));
  // free-running master clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // random traffic on the controller user side and the engine
  always @(posedge mclk) begin
    rnd = $random(seed);
    word_gap <= &rnd[27:24]; // rare gaps so the pins often sit still
    engine_en <= rnd[1];
    fmt_req <= rnd[3:2];
    wl_req <= rnd[4];
    de_req <= rnd[5];
    engine_in <= rnd[23:6];
  end
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // pin pair order gives right, i2s, left, dsp
  function automatic logic [1:0] exp_fmt(input logic hi, input logic lo);
    return {hi, lo};
  endfunction
  // bounded wait for both devices to run
  task automatic wait_run;
    for (i = 0; i < 40 && (engine_run !== 1'b1 || b_run !== 1'b1); i++) @(negedge mclk);
    chk(18'({engine_run, b_run}), 18'h00003);
  endtask
  // new pins on the second link, held off until a word starts
  task automatic cfg_step(input logic [3:0] v);
    @(posedge mclk);
    {link_b.input_format_sel_hi, link_b.input_format_sel_lo, link_b.word_len_18, link_b.deemphasis_sel} <= v;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(18'({b_fmt, b_wl, b_de}), 18'(cfg));
    @(posedge mclk);
    word_start <= 1'b1;
    @(posedge mclk);
    word_start <= 1'b0;
    repeat (2) @(negedge mclk);
    cfg = {exp_fmt(v[3], v[2]), v[1:0]};
    chk(18'({b_fmt, b_wl, b_de}), 18'(cfg));
  endtask
  // main sequence
  initial begin
    seed = 79963;
    err_total = 0;
    num_checks = 0;
    cfg = 4'h0;
    arst_n = 1'b0;
    pd_req = 1'b0;
    word_start = 1'b0;
    ctl_wr = 1'b1;
    ctl_chan = 1'b0;
    ctl_data = 7'h7F;
    {word_gap, engine_en, fmt_req, wl_req, de_req, engine_in} = '0;
    {link_b.power_down_reset_n, link_b.input_format_sel_hi, link_b.input_format_sel_lo} = 3'h0;
    {link_b.word_len_18, link_b.deemphasis_sel} = 2'h0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    ctl_wr <= 1'b0;
    link_b.power_down_reset_n <= 1'b1;
    @(negedge mclk);
    chk(18'({powered_down, amp_short, engine_run, chan_ctl_left, chan_ctl_right}), 18'h18000);
    wait_run();
    chk(18'({amp_short, b_sh, b_pd}), 18'h00000);
    chk(18'(ready), 18'h00000);
    for (k = 0; k < 6; k++) begin
      @(posedge mclk);
      mrnd = $random(seed);
      ctl_wr <= 1'b1;
      ctl_chan <= k[0];
      ctl_data <= mrnd[6:0] | 7'h01;
      if (k[0]) rv = mrnd[6:0] | 7'h01;
      else lv = mrnd[6:0] | 7'h01;
    end
    @(posedge mclk);
    ctl_wr <= 1'b0;
    pd_req <= 1'b1;
    @(posedge mclk);
    pd_req <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(18'({b_l, b_r}), 18'({lv, rv}));
    chk(18'({amp_short, powered_down, chan_ctl_left, chan_ctl_right}), 18'h0C000);
    chk(engine_acc, 18'h00000);
    @(posedge mclk);
    link_b.power_down_reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    link_b.power_down_reset_n <= 1'b1;
    @(negedge mclk);
    chk(18'({b_pd, b_l, b_r, b_acc[0]}), 18'h08000);
    chk(b_acc, 18'h00000);
    wait_run();
    for (k = 0; k < 10; k++) begin
      mrnd = $random(seed);
      cfg_step(k < 4 ? {k[1:0], mrnd[1:0]} : mrnd[3:0]);
    end
    end_of_test();
  end
  // watchdog against a hang
  initial begin
    #(25 * 5000);
    err_total = err_total + 1;
    end_of_test();
  end
endmodule

// ==== rtl/adpr_ctrl.sv ====
// controller end: holds reset low long enough, waits for lock, and
// drives configuration pins only between data words, whatever the lock state.
module adpr_ctrl
  import adpr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  adpr_if.ctrl link,
  input wire logic pd_req,
  input wire logic [1:0] fmt_req,
  input wire logic word_len_18_req,
  input wire logic deemph_req,
  input wire logic word_gap,
  output logic ready
);
  // ---------------------------------------------------------------
  // reset pulse and lock wait
  // ---------------------------------------------------------------
  logic [LOCK_CNT_W-1:0] cnt_r;
  logic low_done_r;
  logic pd_pin_r;
  logic ready_r;

  // keep pin low at least the minimum width, then wait for lock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      low_done_r <= 1'b0;
      pd_pin_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (pd_req || !low_done_r) begin
      pd_pin_r <= 1'b0;
      ready_r <= 1'b0;
      if (pd_req) begin
        cnt_r <= '0;
        low_done_r <= 1'b0;
      end else if (cnt_r >= LOCK_CNT_W'(RESET_LOW_MIN_CYC - 1)) begin
        cnt_r <= '0;
        low_done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end else begin
      pd_pin_r <= 1'b1;
      if (!ready_r) begin
        if (cnt_r >= LOCK_CNT_W'(LOCK_WAIT_CYC - 1)) begin
          ready_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration pins, changed only in the gap between words
  // ---------------------------------------------------------------
  logic [1:0] fmt_r;
  logic wl_r;
  logic de_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r <= 2'h0;
      wl_r <= 1'b0;
      de_r <= 1'b0;
    end else if (word_gap) begin
      fmt_r <= fmt_req;
      wl_r <= word_len_18_req;
      de_r <= deemph_req;
    end
  end

  // mclk is this module's own clock and is never gated
  assign link.power_down_reset_n = pd_pin_r;
  assign link.input_format_sel_hi = fmt_r[1];
  assign link.input_format_sel_lo = fmt_r[0];
  assign link.word_len_18 = wl_r;
  assign link.deemphasis_sel = de_r;
  assign ready = ready_r;
endmodule

// ==== rtl/adpr_dev.sv ====
// ---------------------------------------------------------------
// Functional notes
// - low reset pin holds power-down state
// - high reset pin leaves power-down
// - controller keeps master clock running
// - reset low at least four clock periods
// - reset zeroes all digital engine registers
// - analog amplifiers shorted during reset
// - reset loads both channel control defaults
// - controller waits 100 ms after release
// - config pins may change asynchronously
// - config pins settle before next MSB
// - format pins decode four serial modes
// - default: unmuted, attenuation zero
// ---------------------------------------------------------------
module adpr_dev
  import adpr_pkg::*;
(
  input wire logic mclk,
  adpr_if.device link,
  input wire logic word_start,
  input wire logic ctl_wr,
  input wire logic ctl_chan,
  input wire logic [CHAN_REG_W-1:0] ctl_data,
  input wire logic [17:0] engine_in,
  input wire logic engine_en,
  output logic powered_down,
  output logic amp_short,
  output logic engine_run,
  output adpr_fmt_type fmt_mode,
  output logic word_len_18,
  output logic deemph_on,
  output logic [CHAN_REG_W-1:0] chan_ctl_left,
  output logic [CHAN_REG_W-1:0] chan_ctl_right,
  output logic [17:0] engine_acc
);
  // ---------------------------------------------------------------
  // reset release synchroniser
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  // assert asynchronously, release after two master clock edges;
  // the retimed release lets every flop leave reset on one edge
  // and keeps a slow pin edge away from the state machine
  always_ff @(posedge mclk or negedge link.power_down_reset_n) begin
    if (!link.power_down_reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  adpr_state_type state_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ADPR_ST_POWER_DOWN;
    end else begin
      case (state_r)
        ADPR_ST_POWER_DOWN: state_r <= ADPR_ST_WAKE;
        ADPR_ST_WAKE: state_r <= ADPR_ST_RUN;
        ADPR_ST_RUN: state_r <= ADPR_ST_RUN;
        default: state_r <= ADPR_ST_POWER_DOWN;
      endcase
    end
  end

  // amp_short and engine_run follow the state; powered_down drops on the first edge out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      powered_down <= 1'b1;
      amp_short <= 1'b1;
      engine_run <= 1'b0;
    end else begin
      powered_down <= 1'b0;
      amp_short <= (state_r != ADPR_ST_RUN);
      engine_run <= (state_r == ADPR_ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // digital engine stand-in: port, interpolator and modulator stages
  // ---------------------------------------------------------------
  logic engine_go;
  logic [17:0] port_word_r;
  logic port_valid_r;
  logic [17:0] interp_r;
  logic interp_valid_r;

  // words enter only while the engine runs
  assign engine_go = engine_run && engine_en;

  // serial data port stage: latches the incoming word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_word_r <= '0;
      port_valid_r <= 1'b0;
    end else begin
      port_valid_r <= engine_go;
      if (engine_go) begin
        port_word_r <= engine_in;
      end
    end
  end

  // interpolation stage: holds the last word one edge longer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interp_r <= '0;
      interp_valid_r <= 1'b0;
    end else begin
      interp_valid_r <= port_valid_r;
      if (port_valid_r) begin
        interp_r <= port_word_r;
      end
    end
  end

  // modulator stage: accumulates words, wrapping at 18 bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      engine_acc <= '0;
    end else if (interp_valid_r) begin
      engine_acc <= engine_acc + interp_r;
    end
  end

  // ---------------------------------------------------------------
  // channel control registers
  // ---------------------------------------------------------------
  logic [CHAN_REG_W-1:0] chan_r [NUM_CHAN];

  // writes during reset are lost: reset wins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          chan_r[gi] <= CHAN_REG_RESET;
        end else if (ctl_wr && (ctl_chan == 1'(gi))) begin
          chan_r[gi] <= ctl_data;
        end
      end
    end
  endgenerate
  assign chan_ctl_left = chan_r[0];
  assign chan_ctl_right = chan_r[1];

  // ---------------------------------------------------------------
  // configuration pin synchronisers (three stages)
  // ---------------------------------------------------------------
  logic [3:0] cfg_pins;
  logic [3:0] cfg_s1_r;
  logic [3:0] cfg_s2_r;
  logic [3:0] cfg_s3_r;
  logic [3:0] cfg_stable_r;

  assign cfg_pins = {link.input_format_sel_hi, link.input_format_sel_lo,
                     link.word_len_18, link.deemphasis_sel};

  // pins may toggle at any time; sample through the chain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_r <= 4'h0;
      cfg_s2_r <= 4'h0;
      cfg_s3_r <= 4'h0;
    end else begin
      cfg_s1_r <= cfg_pins;
      cfg_s2_r <= cfg_s1_r;
      cfg_s3_r <= cfg_s2_r;
    end
  end

  // accept a bit once the second and third stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_stable_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cfg_s2_r[i] == cfg_s3_r[i]) begin
          cfg_stable_r[i] <= cfg_s3_r[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apply configuration only at the start of a data word
  // ---------------------------------------------------------------
  // a word already in flight keeps the settings it began with
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_mode <= ADPR_FMT_RIGHT_JUST;
      word_len_18 <= 1'b0;
      deemph_on <= 1'b0;
    end else if (word_start) begin
      fmt_mode <= adpr_decode_fmt(cfg_stable_r[3], cfg_stable_r[2]);
      word_len_18 <= cfg_stable_r[1];
      deemph_on <= cfg_stable_r[0];
    end
  end
endmodule

// ==== rtl/adpr_if.sv ====
interface adpr_if;
  logic power_down_reset_n;
  logic input_format_sel_lo;
  logic input_format_sel_hi;
  logic word_len_18;
  logic deemphasis_sel;

  modport device (
    input power_down_reset_n,
    input input_format_sel_lo,
    input input_format_sel_hi,
    input word_len_18,
    input deemphasis_sel
  );
  modport ctrl (
    output power_down_reset_n,
    output input_format_sel_lo,
    output input_format_sel_hi,
    output word_len_18,
    output deemphasis_sel
  );
endinterface

// ==== rtl/adpr_pkg.sv ====
package adpr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS = 25;
  localparam int unsigned RESET_LOW_MIN_PERIODS = 4;
  localparam int unsigned RESET_LOW_MIN_CYC = RESET_LOW_MIN_PERIODS;
  localparam int unsigned LOCK_WAIT_MS = 100;
  localparam int unsigned LOCK_WAIT_CYC = (LOCK_WAIT_MS * 1000000) / MCLK_PERIOD_NS;
  localparam int unsigned LOCK_CNT_W = 22;

  // ---------------------------------------------------------------
  // channel control register layout and reset value
  // ---------------------------------------------------------------
  localparam int unsigned CHAN_REG_W = 7;
  localparam int unsigned MUTE_BIT = 6;
  localparam int unsigned ATTEN_LSB = 0;
  localparam int unsigned ATTEN_W = 6;
  localparam logic [6:0] CHAN_REG_RESET = 7'h00;
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADPR_FMT_RIGHT_JUST,
    ADPR_FMT_I2S,
    ADPR_FMT_LEFT_JUST,
    ADPR_FMT_DSP
  } adpr_fmt_type;

  typedef enum logic [1:0] {
    ADPR_ST_POWER_DOWN,
    ADPR_ST_WAKE,
    ADPR_ST_RUN
  } adpr_state_type;

  // decode of the two format select pins, hi pin is the upper bit
  function automatic adpr_fmt_type adpr_decode_fmt(input logic sel_hi, input logic sel_lo);
    case ({sel_hi, sel_lo})
      2'h0: adpr_decode_fmt = ADPR_FMT_RIGHT_JUST;
      2'h1: adpr_decode_fmt = ADPR_FMT_I2S;
      2'h2: adpr_decode_fmt = ADPR_FMT_LEFT_JUST;
      default: adpr_decode_fmt = ADPR_FMT_DSP;
    endcase
  endfunction
endpackage
